/* File: hdl/rtci_params.svh */
// Constants for the interrupt and clock-output logic
`ifndef RTCI_PARAMS_SVH
`define RTCI_PARAMS_SVH

// Register offsets
`define RTCI_ADDR_CTL_ONE      4'he
`define RTCI_ADDR_CTL_TWO      4'hf

// Field positions, control_one
`define RTCI_BIT_WEEKLY_EN     7
`define RTCI_BIT_DAILY_EN      6
`define RTCI_BIT_CLKEN_N_B     4
`define RTCI_SEL_MSB           2
`define RTCI_SEL_LSB           0

// Field positions, control_two
`define RTCI_BIT_CLKEN_N_A     3
`define RTCI_BIT_PER_FLAG      2
`define RTCI_BIT_WEEKLY_FLAG   1
`define RTCI_BIT_DAILY_FLAG    0

// Reset values (oscillator-halt defaults)
`define RTCI_RST_CTL_ONE       8'h00
`define RTCI_RST_CTL_TWO       8'h00

// Periodic select codes
`define RTCI_SEL_OFF           3'h0
`define RTCI_SEL_LOW           3'h1
`define RTCI_SEL_2HZ           3'h2
`define RTCI_SEL_1HZ           3'h3
`define RTCI_SEL_SEC           3'h4
`define RTCI_SEL_MIN           3'h5
`define RTCI_SEL_HOUR          3'h6
`define RTCI_SEL_MONTH         3'h7

// Timing
`define RTCI_CLK_HZ            100000000
`define RTCI_OSC_HZ            32768
`define RTCI_ACC_STEP          28'd65536
`define RTCI_ACC_MOD           28'd100000000
`define RTCI_SUB_LEN           16'h8000
`define RTCI_FALL_LEAD_US      92
`define RTCI_FALL_LEAD_TICKS   ((`RTCI_FALL_LEAD_US * `RTCI_OSC_HZ) / 1000000)
`define RTCI_ADJ_PERIOD_S      20
`define RTCI_ADJ_MAX_US        3784
`define RTCI_ADJ_MAX_TICKS     ((`RTCI_ADJ_MAX_US * `RTCI_OSC_HZ) / 1000000)

`endif

/* File: hdl/rtci_pkg.sv */
// Types for the interrupt and clock-output logic
`default_nettype none
package rtci_pkg;

    typedef logic [2:0] rtci_sel_type;

    typedef struct packed {
        logic         weekly_en;
        logic         daily_en;
        logic         clken_n_b;
        rtci_sel_type sel;
    } rtci_ctl_one_type;

    typedef struct packed {
        logic [6:0] dow_mask;
        logic [7:0] hour;
        logic [7:0] minute;
    } rtci_alarm_set_type;

    typedef struct packed {
        logic [2:0] dow;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic [7:0] mday;
    } rtci_time_type;

    typedef struct packed {
        logic match_prev;
        logic hit;
    } rtci_alarm_state_type;

    typedef struct packed {
        rtci_ctl_one_type ctl;
        logic             clken_n_a;
        logic             weekly_flag;
        logic             daily_flag;
        logic             periodic_flag;
        logic [15:0]      sub;
        logic [27:0]      acc;
        logic             osc_lvl;
        logic             gate;
        logic [4:0]       sec20;
        logic             sec_tick;
        logic             tick_d;
        logic             irq_oe;
        logic             clk_oe;
        logic [7:0]       rdata;
    } rtci_state_type;

endpackage
`default_nettype wire

/* File: hdl/rtci_alarm.sv */
// Alarm comparator with edge-only hit
`default_nettype none
module rtci_alarm #(
    parameter bit USE_DOW = 1'b1
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // Control
    input  wire logic                        enable,
    // Current time and alarm setting
    input  wire rtci_pkg::rtci_time_type      cur,
    input  wire rtci_pkg::rtci_alarm_set_type al,
    // Result
    output logic                             hit
);

    rtci_pkg::rtci_alarm_state_type s_r;
    rtci_pkg::rtci_alarm_state_type s_nxt;
    logic                           match;

    always_comb begin
        match = (cur.hour == al.hour) && (cur.minute == al.minute);
        if (USE_DOW) begin
            match = match && al.dow_mask[cur.dow];
        end
        s_nxt = s_r;
        s_nxt.match_prev = match;
        // Only entry into a match counts, so a cleared flag stays clear
        s_nxt.hit = enable && match && !s_r.match_prev;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hit = s_r.hit;

    property p_hit_needs_enable;
        @(posedge clk) disable iff (reset)
        hit |-> $past(enable);
    endproperty
    a_hit_needs_enable: assert property (p_hit_needs_enable)
        else $error("alarm hit while comparator disabled");

    property p_hit_single;
        @(posedge clk) disable iff (reset)
        hit |=> !hit [*2];
    endproperty
    a_hit_single: assert property (p_hit_single)
        else $error("alarm hit repeated during one match");

endmodule // rtci_alarm
`default_nettype wire

/* File: hdl/rtci_top.sv */
// Alarm, periodic interrupt and gated clock output of the clock chip
`include "rtci_params.svh"
`default_nettype none
module rtci_top #(
    parameter bit GATED = 1'b1
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // Register port
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [3:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    output logic      [7:0]                  reg_rdata,
    // Time counters and alarm settings
    input  wire rtci_pkg::rtci_time_type      cur_time,
    input  wire logic                        sec_write,
    input  wire rtci_pkg::rtci_alarm_set_type weekly_set,
    input  wire rtci_pkg::rtci_alarm_set_type daily_set,
    // Oscillation adjustment, signed oscillator ticks
    input  wire logic                        adj_enable,
    input  wire logic [7:0]                  adj_delta,
    // Seconds increment to the time counters
    output logic                             sec_tick,
    // Open-drain pins
    output logic                             irq_n_pin_out,
    output logic                             irq_n_pin_oe,
    output logic                             osc_clock_out_pin_out,
    output logic                             osc_clock_out_pin_oe
);

    localparam logic [14:0] LEAD    = 15'(`RTCI_FALL_LEAD_TICKS);
    localparam logic [7:0]  ADJ_MAX = 8'(`RTCI_ADJ_MAX_TICKS);
    localparam logic [4:0]  ADJ_END = 5'(`RTCI_ADJ_PERIOD_S - 1);

    rtci_pkg::rtci_state_type s_r;
    rtci_pkg::rtci_state_type s_nxt;

    logic        weekly_hit;
    logic        daily_hit;
    logic        wr_one;
    logic        wr_two;
    logic [28:0] acc_sum;
    logic        osc_tick;
    logic [7:0]  delta;
    logic [15:0] sec_len;
    logic [14:0] phase;
    logic        pulse_low;
    logic        level_ev;
    logic        per_active;
    logic        want_clk;

    // Clamp adjustment to the documented span
    function automatic logic [7:0] clamp_delta(input logic [7:0] d);
        logic [7:0] mag;
        mag = d[7] ? 8'(-d) : d;
        if (mag > ADJ_MAX) begin
            return d[7] ? 8'(-ADJ_MAX) : ADJ_MAX;
        end
        return d;
    endfunction

    rtci_alarm #(
        .USE_DOW (1'b1)
    ) u_weekly (
        .clk     (clk),
        .reset   (reset),
        .enable  (s_r.ctl.weekly_en),
        .cur     (cur_time),
        .al      (weekly_set),
        .hit     (weekly_hit)
    );

    rtci_alarm #(
        .USE_DOW (1'b0)
    ) u_daily (
        .clk     (clk),
        .reset   (reset),
        .enable  (s_r.ctl.daily_en),
        .cur     (cur_time),
        .al      (daily_set),
        .hit     (daily_hit)
    );

    always_comb begin
        s_nxt = s_r;
        wr_one = reg_wr && (reg_addr == `RTCI_ADDR_CTL_ONE);
        wr_two = reg_wr && (reg_addr == `RTCI_ADDR_CTL_TWO);

        // Fractional divider: two half-periods per oscillator cycle
        acc_sum = {1'b0, s_r.acc} + {1'b0, `RTCI_ACC_STEP};
        osc_tick = 1'b0;
        if (acc_sum >= {1'b0, `RTCI_ACC_MOD}) begin
            s_nxt.acc = 28'(acc_sum - {1'b0, `RTCI_ACC_MOD});
            s_nxt.osc_lvl = !s_r.osc_lvl;
            osc_tick = !s_r.osc_lvl;
        end else begin
            s_nxt.acc = acc_sum[27:0];
        end

        // One second in twenty is stretched or shrunk
        delta = (adj_enable && (s_r.sec20 == ADJ_END)) ? clamp_delta(adj_delta) : 8'h00;
        sec_len = `RTCI_SUB_LEN + {{8{delta[7]}}, delta};

        s_nxt.sec_tick = 1'b0;
        // Sixteen bits so a stretched second can pass 32768 ticks
        if (sec_write) begin
            s_nxt.sub = 16'h0000;
            s_nxt.sec20 = 5'h00;
        end else if (osc_tick) begin
            if (s_r.sub >= 16'(sec_len - 16'h0001)) begin
                s_nxt.sub = 16'h0000;
                s_nxt.sec_tick = 1'b1;
                s_nxt.sec20 = (s_r.sec20 == ADJ_END) ? 5'h00 : 5'(s_r.sec20 + 5'h01);
            end else begin
                s_nxt.sub = s_r.sub + 16'h0001;
            end
        end
        s_nxt.tick_d = s_r.sec_tick;

        // Pulse falls a few ticks ahead of the increment
        phase = 15'(s_r.sub + {1'b0, LEAD});
        pulse_low = 1'b0;
        unique case (s_r.ctl.sel)
            `RTCI_SEL_2HZ: pulse_low = !phase[13];
            `RTCI_SEL_1HZ: pulse_low = !phase[14];
            default:       pulse_low = 1'b0;
        endcase

        // Time counters show the new second one cycle after the tick
        level_ev = 1'b0;
        if (s_r.tick_d) begin
            unique case (s_r.ctl.sel)
                `RTCI_SEL_SEC:   level_ev = 1'b1;
                `RTCI_SEL_MIN:   level_ev = (cur_time.second == 8'h00);
                `RTCI_SEL_HOUR:  level_ev = (cur_time.second == 8'h00)
                                         && (cur_time.minute == 8'h00);
                `RTCI_SEL_MONTH: level_ev = (cur_time.second == 8'h00)
                                         && (cur_time.minute == 8'h00)
                                         && (cur_time.hour == 8'h00)
                                         && (cur_time.mday == 8'h01);
                default:         level_ev = 1'b0;
            endcase
        end

        // Register writes
        if (wr_one) begin
            s_nxt.ctl.weekly_en = reg_wdata[`RTCI_BIT_WEEKLY_EN];
            s_nxt.ctl.daily_en  = reg_wdata[`RTCI_BIT_DAILY_EN];
            s_nxt.ctl.clken_n_b = reg_wdata[`RTCI_BIT_CLKEN_N_B];
            s_nxt.ctl.sel       = reg_wdata[`RTCI_SEL_MSB:`RTCI_SEL_LSB];
        end
        if (wr_two) begin
            s_nxt.clken_n_a = reg_wdata[`RTCI_BIT_CLKEN_N_A];
        end

        // Flags: write one ignored, write zero clears, a hit wins
        if (weekly_hit) begin
            s_nxt.weekly_flag = 1'b1;
        end else if (wr_two && !reg_wdata[`RTCI_BIT_WEEKLY_FLAG]) begin
            s_nxt.weekly_flag = 1'b0;
        end
        if (daily_hit) begin
            s_nxt.daily_flag = 1'b1;
        end else if (wr_two && !reg_wdata[`RTCI_BIT_DAILY_FLAG]) begin
            s_nxt.daily_flag = 1'b0;
        end
        if (level_ev) begin
            s_nxt.periodic_flag = 1'b1;
        end else if (!s_r.ctl.sel[2]) begin
            s_nxt.periodic_flag = 1'b0;
        end else if (wr_two && !reg_wdata[`RTCI_BIT_PER_FLAG]) begin
            s_nxt.periodic_flag = 1'b0;
        end

        unique case (s_r.ctl.sel)
            `RTCI_SEL_OFF: per_active = 1'b0;
            `RTCI_SEL_LOW: per_active = 1'b1;
            `RTCI_SEL_2HZ,
            `RTCI_SEL_1HZ: per_active = pulse_low;
            default:       per_active = s_r.periodic_flag;
        endcase

        // Wired-OR of all active-low sources
        s_nxt.irq_oe = s_r.weekly_flag || s_r.daily_flag || per_active;

        // Gate moves only as the clock goes high, so no runt pulse leaves
        want_clk = GATED ? (!s_r.clken_n_a || !s_r.ctl.clken_n_b) : 1'b1;
        if (osc_tick) begin
            s_nxt.gate = want_clk;
        end
        s_nxt.clk_oe = s_nxt.gate && !s_nxt.osc_lvl;

        // Read data, pulse-mode flag shows the output level
        if (reg_rd) begin
            if (reg_addr == `RTCI_ADDR_CTL_ONE) begin
                s_nxt.rdata = {s_r.ctl.weekly_en, s_r.ctl.daily_en, 1'b0,
                               s_r.ctl.clken_n_b, 1'b0, s_r.ctl.sel};
            end else if (reg_addr == `RTCI_ADDR_CTL_TWO) begin
                s_nxt.rdata = {4'h0, s_r.clken_n_a,
                               s_r.ctl.sel[2] ? s_r.periodic_flag : pulse_low,
                               s_r.weekly_flag, s_r.daily_flag};
            end else begin
                s_nxt.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata             = s_r.rdata;
    assign sec_tick              = s_r.sec_tick;
    assign irq_n_pin_out         = 1'b0;
    assign irq_n_pin_oe          = s_r.irq_oe;
    assign osc_clock_out_pin_out = 1'b0;
    assign osc_clock_out_pin_oe  = s_r.clk_oe;

    property p_flag_clear;
        @(posedge clk) disable iff (reset)
        (reg_wr && reg_addr == `RTCI_ADDR_CTL_TWO && !reg_wdata[1] && !weekly_hit)
            |=> !s_r.weekly_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("weekly flag not cleared by write of zero");

    property p_flag_keep;
        @(posedge clk) disable iff (reset)
        (reg_wr && reg_addr == `RTCI_ADDR_CTL_TWO && reg_wdata[0] && s_r.daily_flag)
            |=> s_r.daily_flag;
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("daily flag changed by write of one");

    property p_enable_kept;
        @(posedge clk) disable iff (reset)
        (reg_wr && reg_addr == `RTCI_ADDR_CTL_TWO)
            |=> $stable(s_r.ctl.weekly_en) && $stable(s_r.ctl.daily_en);
    endproperty
    a_enable_kept: assert property (p_enable_kept)
        else $error("alarm enable changed by flag write");

    property p_alarm_to_pin;
        @(posedge clk) disable iff (reset)
        $rose(s_r.weekly_flag) |=> irq_n_pin_oe;
    endproperty
    a_alarm_to_pin: assert property (p_alarm_to_pin)
        else $error("interrupt pin not driven for alarm flag");

    property p_fixed_low;
        @(posedge clk) disable iff (reset)
        (s_r.ctl.sel == `RTCI_SEL_LOW) [*2] |-> irq_n_pin_oe;
    endproperty
    a_fixed_low: assert property (p_fixed_low)
        else $error("select one did not hold interrupt low");

    property p_off;
        @(posedge clk) disable iff (reset)
        (s_r.ctl.sel == `RTCI_SEL_OFF && !s_r.weekly_flag && !s_r.daily_flag)
            |=> !irq_n_pin_oe;
    endproperty
    a_off: assert property (p_off)
        else $error("interrupt driven with all sources off");

    property p_sec_level;
        @(posedge clk) disable iff (reset)
        (s_r.tick_d && s_r.ctl.sel == `RTCI_SEL_SEC) |=> s_r.periodic_flag ##1 irq_n_pin_oe;
    endproperty
    a_sec_level: assert property (p_sec_level)
        else $error("per-second level interrupt missing");

    property p_secw_low;
        @(posedge clk) disable iff (reset)
        (sec_write && s_r.ctl.sel == `RTCI_SEL_1HZ && !reg_wr) |=> ##1 irq_n_pin_oe;
    endproperty
    a_secw_low: assert property (p_secw_low)
        else $error("seconds write did not drive pulse output low");

    property p_gate_edge;
        @(posedge clk) disable iff (reset)
        $changed(s_r.gate) |-> s_r.osc_lvl && !osc_clock_out_pin_oe;
    endproperty
    a_gate_edge: assert property (p_gate_edge)
        else $error("clock gate changed while output low");

    property p_daily_clear;
        @(posedge clk) disable iff (reset)
        (wr_two && !reg_wdata[`RTCI_BIT_DAILY_FLAG] && !daily_hit)
            |=> !s_r.daily_flag;
    endproperty
    a_daily_clear: assert property (p_daily_clear)
        else $error("daily flag not cleared by write of zero");

    property p_per_clear;
        @(posedge clk) disable iff (reset)
        (wr_two && !reg_wdata[`RTCI_BIT_PER_FLAG] && !level_ev)
            |=> !s_r.periodic_flag;
    endproperty
    a_per_clear: assert property (p_per_clear)
        else $error("periodic flag not cleared by write of zero");

    property p_hit_to_flag;
        @(posedge clk) disable iff (reset)
        daily_hit |=> s_r.daily_flag;
    endproperty
    a_hit_to_flag: assert property (p_hit_to_flag)
        else $error("daily alarm hit not recorded in flag");

    property p_clk_off;
        @(posedge clk) disable iff (reset)
        (GATED && s_r.clken_n_a && s_r.ctl.clken_n_b && !s_r.gate)
            |=> !osc_clock_out_pin_oe;
    endproperty
    a_clk_off: assert property (p_clk_off)
        else $error("clock output driven with both enables off");

    property p_wired;
        @(posedge clk) disable iff (reset)
        s_r.daily_flag |=> irq_n_pin_oe;
    endproperty
    a_wired: assert property (p_wired)
        else $error("interrupt pin not driven for daily flag");

endmodule // rtci_top
`default_nettype wire

/* File: bench/rtci_host.sv */
// Host processor model for the register port and alarm settings
`include "rtci_params.svh"
`default_nettype none
module rtci_host (
    // Clock
    input  wire logic                    clk,
    // Register port
    output logic                         reg_wr,
    output logic                         reg_rd,
    output logic [3:0]                   reg_addr,
    output logic [7:0]                   reg_wdata,
    input  wire logic [7:0]              reg_rdata,
    // Alarm settings
    output rtci_pkg::rtci_alarm_set_type weekly_set,
    output rtci_pkg::rtci_alarm_set_type daily_set
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] ctl1;

    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        weekly_set = '0;
        daily_set = '0;
        ctl1 = 8'h00;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        // Released data must not look valid
        reg_wdata <= ~d;
        if (a == `RTCI_ADDR_CTL_ONE) begin
            ctl1 = d;
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic set_alarms(input rtci_pkg::rtci_alarm_set_type w,
                              input rtci_pkg::rtci_alarm_set_type d, input logic [1:0] en);
        wr(`RTCI_ADDR_CTL_ONE, {2'b00, ctl1[5:0]});
        @(posedge clk);
        weekly_set <= w;
        daily_set <= d;
        wr(`RTCI_ADDR_CTL_ONE, {en, ctl1[5:0]});
    endtask
endmodule // rtci_host
`default_nettype wire

/* File: bench/rtci_top_tb.sv */
// Self-checking bench for the interrupt and clock-output logic
`include "rtci_params.svh"
`default_nettype none
module rtci_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0] E = `RTCI_ADDR_CTL_ONE;
    localparam logic [3:0] F = `RTCI_ADDR_CTL_TWO;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, r;
    rtci_pkg::rtci_time_type cur_time = '0;
    rtci_pkg::rtci_time_type t, t0;
    rtci_pkg::rtci_alarm_set_type weekly_set, daily_set, w, d;
    logic sec_write = 1'b0;
    logic adj_enable = 1'b0;
    logic [7:0] adj_delta = 8'h00;
    logic sec_tick, irq_out, irq_oe, ck_out, ck_oe, irq_n, ck_n, ck_prev;
    logic [1:0] en, ex;
    int fail_count = 0;
    int comparisons = 0;
    int seed = 77342;
    int cycles = 0;
    int rises = 0;
    int run = 0;

    always #5 clk = ~clk;

    // Pull-ups on both open-drain pins
    assign irq_n = irq_oe ? irq_out : 1'b1;
    assign ck_n = ck_oe ? ck_out : 1'b1;

    rtci_top rtci_top_i (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cur_time(cur_time), .sec_write(sec_write), .weekly_set(weekly_set),
        .daily_set(daily_set), .adj_enable(adj_enable), .adj_delta(adj_delta),
        .sec_tick(sec_tick), .irq_n_pin_out(irq_out), .irq_n_pin_oe(irq_oe),
        .osc_clock_out_pin_out(ck_out), .osc_clock_out_pin_oe(ck_oe));

    rtci_host rtci_host_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .weekly_set(weekly_set),
        .daily_set(daily_set));

    task automatic finish_test();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    function automatic logic [1:0] hits(input rtci_pkg::rtci_time_type c,
        input rtci_pkg::rtci_alarm_set_type aw, input rtci_pkg::rtci_alarm_set_type ad);
        hits[1] = aw.dow_mask[c.dow] && c.hour == aw.hour && c.minute == aw.minute;
        hits[0] = c.hour == ad.hour && c.minute == ad.minute;
    endfunction

    task automatic set_time(input rtci_pkg::rtci_time_type c);
        @(posedge clk);
        cur_time <= c;
    endtask

    // A clean gated clock never shows a short low pulse
    always @(posedge clk) begin
        cycles++;
        if (cycles > 40000) begin
            fail_count++;
            finish_test();
        end
        ck_prev <= ck_oe;
        if (!reset && ck_oe === 1'b1) begin
            run++;
            if (ck_prev !== 1'b1) begin
                rises++;
            end
        end else begin
            if (run > 0 && run < 700) begin
                chk8(8'h00, 8'h01);
            end
            run = 0;
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rtci_host_i.rd(E, r);
        chk8(r, 8'h00);
        rtci_host_i.rd(F, r);
        chk8(r, 8'h00);
        rtci_host_i.wr(4'h3, 8'hff);
        rtci_host_i.rd(4'h3, r);
        chk8(r, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rtci_host_i.wr(E, {5'h00, 3'(i)});
            rtci_host_i.rd(E, r);
            chk8(r, {5'h00, 3'(i)});
            if (i < 2) begin
                chk1(irq_n, ~i[0]);
            end
        end
        for (int i = 2; i < 4; i++) begin
            rtci_host_i.wr(E, {5'h00, 3'(i)});
            @(posedge clk);
            sec_write <= 1'b1;
            @(posedge clk);
            sec_write <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            chk1(irq_n, 1'b0);
            rtci_host_i.rd(F, r);
            chk1(r[2], 1'b1);
        end
        rtci_host_i.wr(E, 8'h00);
        for (int i = 0; i < 12; i++) begin
            w = 23'($random(seed));
            d = 23'($random(seed));
            t = 35'({$random(seed), $random(seed)});
            en = (i < 4) ? 2'b11 : 2'($random(seed));
            if (t.dow == 3'h7) begin
                t.dow = 3'h0;
            end
            if (i % 4 == 2) begin
                d.hour = w.hour;
                d.minute = w.minute;
            end
            if (i % 4 == 1 || i % 4 == 2) begin
                w.dow_mask[t.dow] = 1'b1;
                t.hour = w.hour;
                t.minute = w.minute;
            end else if (i % 4 == 0) begin
                t.hour = d.hour;
                t.minute = d.minute;
            end
            t0 = t;
            t0.minute = ~t.minute;
            ex = en & hits(t, w, d) & ~hits(t0, w, d);
            set_time(t0);
            rtci_host_i.wr(F, 8'h00);
            rtci_host_i.set_alarms(w, d, en);
            set_time(t);
            repeat (4) @(posedge clk);
            rtci_host_i.rd(F, r);
            chk8(r, {6'h00, ex});
            chk1(irq_n, ~|ex);
            rtci_host_i.wr(F, 8'h01);
            rtci_host_i.rd(F, r);
            chk8(r, {7'h00, ex[0]});
            chk1(irq_n, ~ex[0]);
            rtci_host_i.wr(F, 8'h00);
            repeat (4) @(posedge clk);
            rtci_host_i.rd(F, r);
            chk8(r, 8'h00);
            chk1(irq_n, 1'b1);
            rtci_host_i.rd(E, r);
            chk8(r, {en, 6'h00});
            set_time(t0);
            set_time(t);
            repeat (4) @(posedge clk);
            rtci_host_i.rd(F, r);
            chk8(r, {6'h00, ex});
        end
        rtci_host_i.wr(E, 8'h10);
        rises = 0;
        // Two full output periods, so two rises whatever the phase
        repeat (6500) @(posedge clk);
        chk1(rises > 1, 1'b1);
        rtci_host_i.wr(F, 8'h08);
        repeat (2000) @(posedge clk);
        rises = 0;
        repeat (4000) @(posedge clk);
        chk8(8'(rises), 8'h00);
        chk1(ck_n, 1'b1);
        rtci_host_i.wr(E, 8'h00);
        rises = 0;
        repeat (6500) @(posedge clk);
        chk1(rises > 1, 1'b1);
        finish_test();
    end
endmodule // rtci_top_tb
`default_nettype wire
